//--- rtl/fspc_consts.svh
// Purpose: Constants of the flash self-program control block.
// Assumes: A 250 MHz CPU clock, 14-bit word addresses.
// Notes: Offsets, fields, resets, commands and timing counts.
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH
`define FSPC_CTL_IO_ADDR 8'h37
`define FSPC_DS_OFFSET 8'h20
`define FSPC_CTL_RESET 8'h00
`define FSPC_BIT_IRQ_EN 7
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_RSVD 5
`define FSPC_BIT_OP_EN 0
`define FSPC_CMD_READ_EN 5'h11
`define FSPC_CMD_LOCK 5'h09
`define FSPC_CMD_PG_WRITE 5'h05
`define FSPC_CMD_PG_ERASE 5'h03
`define FSPC_CMD_FILL 5'h01
`define FSPC_SPM_WIN 3'h4
`define FSPC_LPM_WIN 3'h3
`define FSPC_CLK_PERIOD_PS 4000
`define FSPC_PROG_MAX_NS 4500000
`define FSPC_PROG_MAX_CYC (`FSPC_PROG_MAX_NS / (`FSPC_CLK_PERIOD_PS / 1000))
`define FSPC_PROG_RC_TICKS 3700
`define FSPC_PAGE_WORDS 64
`define FSPC_RWW_PAGES 8'hE0
`define FSPC_BOOT_256 14'h3F00
`define FSPC_BOOT_512 14'h3E00
`define FSPC_BOOT_1K 14'h3C00
`define FSPC_BOOT_2K 14'h3800
`define FSPC_LOCK_RESET 8'hFF
`define FSPC_LOCK_PROG_MASK 8'h3C
`define FSPC_ERASED_WORD 16'hFFFF
`endif

//--- rtl/fspc_ctrl.sv
// Purpose: Self-program control of on-chip flash driven by the CPU.
// Assumes: CPU strobes are synchronous; rc_tick is the calibrated RC clock
//   already brought into this domain as a one-cycle pulse.
// Notes: The control register answers at one I/O offset and its data-space alias.
// Notes on behaviour
// - Each erase, write or lock ends within 4.5 ms.
// - Programming time counted on RC oscillator ticks.
// - Boot size fuse picks boot section start.
// - Pages below 224 form the read-while-write section.
// - Z bits 14-7 pick page, 6-1 word.
// - Z bit 15 ignored; bits 1-0 select LPM byte.
// - Register at I/O 0x37 and data 0x57.
// - Ready interrupt while enabled and op idle.
// - Erase or write to section sets busy.
// - Buffer fill clears the busy flag.
// - Read-enable command clears busy when idle.
// - Read-enable write during fill discards buffer.
// - Lock command programs lock bits from R0.
// - LPM in three cycles reads lock/fuse.
// - Page write command writes buffer to page.
// - Write to the other section halts CPU.
// - Erase command erases addressed page.
// - Fill stores R1:R0; enable bit times out.
// - Undefined command patterns do not arm; one with bit 4 set still discards the buffer.
// - EEPROM write blocks programming and fuse reads.
`timescale 1ns/100ps
`include "fspc_consts.svh"
module fspc_ctrl #(
  parameter int unsigned PROG_RC_TICKS = `FSPC_PROG_RC_TICKS,
  parameter int unsigned PROG_MAX_CYC = `FSPC_PROG_MAX_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic io_space,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic spm_exec,
  input wire logic lpm_exec,
  input wire logic [15:0] z_ptr,
  input wire logic [7:0] r0_data,
  input wire logic [7:0] r1_data,
  input wire logic gie,
  input wire logic eeprom_write_busy,
  input wire logic boot_size_hi,
  input wire logic boot_size_lo,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic rc_tick,
  output logic lpm_take,
  output logic [7:0] lpm_data,
  output logic spm_irq,
  output logic cpu_halt,
  output logic rw_section_busy,
  output logic [13:0] boot_start,
  output logic flash_start,
  output fspc_pkg::fspc_op_t flash_op,
  output logic [7:0] flash_page,
  output logic flash_wstrb,
  output logic [5:0] flash_wword,
  output logic [15:0] flash_wdata,
  output logic [7:0] lock_bits
);
  import fspc_pkg::*;

  localparam int unsigned RCW = $clog2(PROG_RC_TICKS + 1);
  localparam int unsigned CYW = $clog2(PROG_MAX_CYC + 1);

  if (PROG_RC_TICKS < 1 || PROG_MAX_CYC < 2) begin : g_chk
    $error("fspc_ctrl: program time counts too small");
  end

  fspc_state_t st_r;
  fspc_op_t op_r;
  logic irq_en_r;
  logic busy_r;
  logic [4:1] cmd_r;
  logic [2:0] win_r;
  logic [7:0] page_r;
  logic [RCW-1:0] rc_cnt_r;
  logic [CYW-1:0] cyc_cnt_r;
  logic halt_r;
  logic [`FSPC_PAGE_WORDS-1:0] valid_r;
  logic [7:0] lock_r;
  logic [7:0] lock_val_r;
  logic [6:0] wr_idx_r;
  logic rd_pend_r;
  logic rd_valid_r;
  logic [5:0] rd_word_r;
  logic [15:0] buf_rd;
  logic wr_hit;
  logic rd_hit;
  logic cmd_ok;
  logic spm_go;
  logic fill_go;
  logic done;
  logic [4:0] wcmd;

  // Matches the I/O offset or its data-space alias.
  function automatic logic addr_hit(input logic io, input logic [7:0] a);
    if (io) begin
      addr_hit = (a == `FSPC_CTL_IO_ADDR);
    end else begin
      addr_hit = (a == `FSPC_CTL_IO_ADDR + `FSPC_DS_OFFSET);
    end
  endfunction

  function automatic logic page_in_rww(input logic [7:0] p);
    page_in_rww = (p < `FSPC_RWW_PAGES);
  endfunction

  assign wr_hit = bus_wr & addr_hit(io_space, bus_addr);
  assign rd_hit = bus_rd & addr_hit(io_space, bus_addr);
  assign wcmd = bus_wdata[4:0];
  assign cmd_ok = (wcmd == `FSPC_CMD_READ_EN) || (wcmd == `FSPC_CMD_LOCK) ||
                  (wcmd == `FSPC_CMD_PG_WRITE) || (wcmd == `FSPC_CMD_PG_ERASE) ||
                  (wcmd == `FSPC_CMD_FILL);
  // An EEPROM write that starts after arming still blocks the store.
  assign spm_go = spm_exec && st_r == FSPC_ST_ARMED && win_r != 3'h0 &&
                  !eeprom_write_busy;
  assign fill_go = spm_go && cmd_r == 4'h0;
  assign done = st_r == FSPC_ST_RUN &&
                ((rc_tick && rc_cnt_r == RCW'(PROG_RC_TICKS - 1)) ||
                 cyc_cnt_r == CYW'(PROG_MAX_CYC - 1));

  always_comb begin
    case ({boot_size_hi, boot_size_lo})
      2'b11: boot_start = `FSPC_BOOT_256;
      2'b10: boot_start = `FSPC_BOOT_512;
      2'b01: boot_start = `FSPC_BOOT_1K;
      default: boot_start = `FSPC_BOOT_2K;
    endcase
  end

  assign spm_irq = irq_en_r & gie & (st_r == FSPC_ST_IDLE);
  assign rw_section_busy = busy_r;
  assign cpu_halt = halt_r;
  assign lock_bits = lock_r;

  // Command arming, the access window and the operation sequence.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= FSPC_ST_IDLE;
      cmd_r <= 4'h0;
      win_r <= 3'h0;
      op_r <= FSPC_OP_NONE;
    end else begin
      case (st_r)
        FSPC_ST_IDLE, FSPC_ST_ARMED: begin
          if (wr_hit && bus_wdata[`FSPC_BIT_OP_EN] && cmd_ok && !eeprom_write_busy) begin
            st_r <= FSPC_ST_ARMED;
            cmd_r <= wcmd[4:1];
            win_r <= `FSPC_SPM_WIN;
          end else if (spm_go) begin
            case ({cmd_r, 1'b1})
              `FSPC_CMD_PG_ERASE: begin
                st_r <= FSPC_ST_RUN;
                op_r <= FSPC_OP_ERASE;
              end
              `FSPC_CMD_PG_WRITE: begin
                st_r <= FSPC_ST_RUN;
                op_r <= FSPC_OP_WRITE;
              end
              `FSPC_CMD_LOCK: begin
                st_r <= FSPC_ST_RUN;
                op_r <= FSPC_OP_LOCK;
              end
              default: begin
                st_r <= FSPC_ST_IDLE;
                cmd_r <= 4'h0;
              end
            endcase
            win_r <= 3'h0;
          end else if (st_r == FSPC_ST_ARMED) begin
            if (win_r <= 3'h1) begin
              st_r <= FSPC_ST_IDLE;
              cmd_r <= 4'h0;
              win_r <= 3'h0;
            end else begin
              win_r <= win_r - 3'h1;
            end
          end
        end
        FSPC_ST_RUN: begin
          if (done) begin
            st_r <= FSPC_ST_IDLE;
            cmd_r <= 4'h0;
            op_r <= FSPC_OP_NONE;
          end
        end
        default: begin
          st_r <= FSPC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_r <= 1'b0;
    end else if (wr_hit) begin
      irq_en_r <= bus_wdata[`FSPC_BIT_IRQ_EN];
    end
  end

  // Section busy: set by an erase or write into the section, cleared by a fill
  // or by the read-enable command once the flash is idle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
    end else if (spm_go && cmd_r[2:1] != 2'b00 && cmd_r[4:3] == 2'b00) begin
      busy_r <= page_in_rww(z_ptr[14:7]) | busy_r;
    end else if (fill_go) begin
      busy_r <= 1'b0;
    end else if (spm_go && {cmd_r, 1'b1} == `FSPC_CMD_READ_EN) begin
      busy_r <= 1'b0;
    end
  end

  // Program time runs on RC ticks, with a CPU-cycle ceiling as a backstop.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rc_cnt_r <= '0;
      cyc_cnt_r <= '0;
    end else if (st_r != FSPC_ST_RUN || done) begin
      rc_cnt_r <= '0;
      cyc_cnt_r <= '0;
    end else begin
      if (rc_tick) begin
        rc_cnt_r <= rc_cnt_r + RCW'(1);
      end
      cyc_cnt_r <= cyc_cnt_r + CYW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      page_r <= 8'h00;
      halt_r <= 1'b0;
      lock_val_r <= 8'h00;
    end else if (spm_go && st_r != FSPC_ST_RUN) begin
      page_r <= z_ptr[14:7];
      lock_val_r <= r0_data;
      halt_r <= (cmd_r[2:1] != 2'b00) && (cmd_r[4:3] == 2'b00) &&
                !page_in_rww(z_ptr[14:7]);
    end else if (done) begin
      halt_r <= 1'b0;
    end
  end

  // Only the boot lock bits can be programmed; and Z play no part.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_r <= `FSPC_LOCK_RESET;
    end else if (done && op_r == FSPC_OP_LOCK) begin
      lock_r <= lock_r & (lock_val_r | ~`FSPC_LOCK_PROG_MASK);
    end
  end

  // Words the buffer really holds; a discarded or written buffer reads erased.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_r <= '0;
    end else if (wr_hit && bus_wdata[4] && valid_r != '0 && st_r != FSPC_ST_RUN) begin
      valid_r <= '0;
    end else if (fill_go) begin
      valid_r[z_ptr[6:1]] <= 1'b1;
    end else if (done && op_r == FSPC_OP_WRITE) begin
      valid_r <= '0;
    end
  end

  fspc_page_buf #(
    .WIDTH(16),
    .DEPTH(`FSPC_PAGE_WORDS)
  ) u_buf (
    .clk(clk),
    .wr_en(fill_go),
    .wr_addr(z_ptr[6:1]),
    .wr_data({r1_data, r0_data}),
    .rd_addr(wr_idx_r[5:0]),
    .rd_data(buf_rd)
  );

  // During a page write the buffer is streamed to the array one word a cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_idx_r <= 7'h40;
      rd_pend_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_word_r <= 6'h00;
    end else begin
      if (spm_go && {cmd_r, 1'b1} == `FSPC_CMD_PG_WRITE) begin
        wr_idx_r <= 7'h00;
      end else if (!wr_idx_r[6]) begin
        wr_idx_r <= wr_idx_r + 7'h01;
      end
      rd_pend_r <= !wr_idx_r[6];
      rd_valid_r <= valid_r[wr_idx_r[5:0]];
      rd_word_r <= wr_idx_r[5:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_start <= 1'b0;
      flash_op <= FSPC_OP_NONE;
      flash_page <= 8'h00;
      flash_wstrb <= 1'b0;
      flash_wword <= 6'h00;
      flash_wdata <= 16'h0000;
    end else begin
      flash_start <= spm_go && cmd_r != 4'h0 && {cmd_r, 1'b1} != `FSPC_CMD_READ_EN;
      flash_op <= op_r;
      flash_page <= page_r;
      flash_wstrb <= rd_pend_r;
      flash_wword <= rd_word_r;
      flash_wdata <= rd_valid_r ? buf_rd : `FSPC_ERASED_WORD;
    end
  end

  // Lock and fuse readback inside the three-cycle window.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lpm_take <= 1'b0;
      lpm_data <= 8'h00;
    end else begin
      lpm_take <= lpm_exec && st_r == FSPC_ST_ARMED && {cmd_r, 1'b1} == `FSPC_CMD_LOCK &&
                  win_r >= 3'h2 && !eeprom_write_busy;
      if (z_ptr[0]) begin
        lpm_data <= lock_r;
      end else if (z_ptr[1]) begin
        lpm_data <= fuse_high;
      end else begin
        lpm_data <= fuse_low;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= `FSPC_CTL_RESET;
    end else if (rd_hit) begin
      bus_rdata <= {irq_en_r, busy_r, 1'b0, cmd_r, st_r != FSPC_ST_IDLE};
    end
  end

  a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
    irq_en_r && gie && st_r == FSPC_ST_IDLE |-> spm_irq)
    else $error("ready interrupt missing");
  a_arm_timeout: assert property (@(posedge clk) disable iff (!arst_n)
    st_r == FSPC_ST_ARMED && win_r == 3'h1 && !spm_exec && !wr_hit |=> st_r == FSPC_ST_IDLE)
    else $error("armed command outlived its window");
  a_arm_window: assert property (@(posedge clk) disable iff (!arst_n)
    wr_hit && cmd_ok && bus_wdata[0] && st_r == FSPC_ST_IDLE && !eeprom_write_busy
    ##1 (!spm_exec && !wr_hit) [*3] |=> st_r == FSPC_ST_ARMED)
    else $error("window shorter than four cycles");
  a_busy_set: assert property (@(posedge clk) disable iff (!arst_n)
    spm_go && {cmd_r, 1'b1} == `FSPC_CMD_PG_ERASE && page_in_rww(z_ptr[14:7])
    |=> rw_section_busy && flash_start)
    else $error("busy not set on erase");
  a_fill_clear: assert property (@(posedge clk) disable iff (!arst_n)
    fill_go |=> !rw_section_busy && st_r == FSPC_ST_IDLE)
    else $error("fill did not clear busy");
  a_run_bound: assert property (@(posedge clk) disable iff (!arst_n)
    st_r == FSPC_ST_RUN |-> cyc_cnt_r < CYW'(PROG_MAX_CYC))
    else $error("program time exceeded");
  a_halt_write: assert property (@(posedge clk) disable iff (!arst_n)
    spm_go && {cmd_r, 1'b1} == `FSPC_CMD_PG_WRITE && !page_in_rww(z_ptr[14:7])
    |=> cpu_halt throughout (st_r == FSPC_ST_RUN) [*2])
    else $error("CPU not halted");
  a_bad_cmd: assert property (@(posedge clk) disable iff (!arst_n)
    wr_hit && !cmd_ok && st_r == FSPC_ST_IDLE |=> st_r == FSPC_ST_IDLE)
    else $error("undefined command took effect");
  a_ee_block: assert property (@(posedge clk) disable iff (!arst_n)
    eeprom_write_busy && st_r == FSPC_ST_IDLE |=> st_r == FSPC_ST_IDLE && !lpm_take)
    else $error("programming during EEPROM write");
  a_discard: assert property (@(posedge clk) disable iff (!arst_n)
    wr_hit && bus_wdata[4] && st_r != FSPC_ST_RUN |=> valid_r == '0)
    else $error("buffer not discarded");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (!arst_n)
    $past(rd_hit) |-> !bus_rdata[`FSPC_BIT_RSVD])
    else $error("reserved bit set");
  a_reenable: assert property (@(posedge clk) disable iff (!arst_n)
    spm_go && {cmd_r, 1'b1} == `FSPC_CMD_READ_EN |=> !rw_section_busy)
    else $error("read enable failed");
endmodule

//--- rtl/fspc_page_buf.sv
// Purpose: Temporary page buffer, one write port and a registered read port.
// Assumes: Write and read share the clock.
// Notes: No reset on the storage; validity is tracked by the owner.
`timescale 1ns/100ps
module fspc_page_buf #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 64
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("fspc_page_buf: bad size");
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

//--- rtl/fspc_pkg.sv
// Purpose: Types shared by the flash self-program control block.
// Assumes: Nothing beyond the constants header.
// Notes: States and flash operation codes.
package fspc_pkg;
  typedef enum logic [1:0] {
    FSPC_ST_IDLE = 2'b00,
    FSPC_ST_ARMED = 2'b01,
    FSPC_ST_RUN = 2'b10
  } fspc_state_t;
  typedef enum logic [1:0] {
    FSPC_OP_NONE = 2'b00,
    FSPC_OP_ERASE = 2'b01,
    FSPC_OP_WRITE = 2'b10,
    FSPC_OP_LOCK = 2'b11
  } fspc_op_t;
endpackage

//--- testbench/fspc_cpu_model.sv
// Purpose: CPU-side model issuing register, store and load program accesses.
// Assumes: Strobes last one clock and change just after a rising edge.
// Notes: The cmd task keeps the software sequencing that the block relies on.
`timescale 1ns/100ps
module fspc_cpu_model (
  input wire logic clk,
  input wire logic eeprom_write_busy,
  input wire logic [7:0] bus_rdata,
  output logic io_space,
  output logic [7:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  output logic spm_exec,
  output logic lpm_exec,
  output logic [15:0] z_ptr,
  output logic [7:0] r0_data,
  output logic [7:0] r1_data
);
  initial begin
    {io_space, bus_addr, bus_wr, bus_rd, bus_wdata, spm_exec, lpm_exec} = '0;
    {z_ptr, r0_data, r1_data} = '0;
  end
  task automatic acc(input logic ds, input logic [7:0] a, input logic wr, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    io_space <= ~ds;
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= wr;
    bus_rd <= ~wr;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    if (!wr) begin
      @(posedge clk);
      #1 q = bus_rdata;
    end
  endtask
  task automatic ex(input logic lpm, input logic [15:0] z, input logic [7:0] r1,
                    input logic [7:0] r0);
    @(posedge clk);
    z_ptr <= z;
    r1_data <= r1;
    r0_data <= r0;
    spm_exec <= ~lpm;
    lpm_exec <= lpm;
    @(posedge clk);
    spm_exec <= 1'b0;
    lpm_exec <= 1'b0;
    // Operands are not held once the instruction is gone.
    z_ptr <= ~z;
    r1_data <= ~r1;
    r0_data <= ~r0;
  endtask
  task automatic cmd(input logic [4:0] c, input logic [15:0] z, input logic [7:0] r1,
                     input logic [7:0] r0);
    logic [7:0] q;
    logic [15:0] zz;
    q = 8'h01;
    while (q[0] || eeprom_write_busy) acc(1'b1, 8'h57, 1'b0, 8'h00, q);
    zz = {z[15:1], 1'b0};
    if (c == 5'h05) zz[6:1] = 6'h00;
    acc(1'b0, 8'h37, 1'b1, {3'b100, c}, q);
    ex(1'b0, zz, r1, r0);
  endtask
endmodule

//--- testbench/tb.sv
// Purpose: Self-checking bench of the flash self-program control block.
// Assumes: Short programming counts: 10 RC ticks, 200-cycle backstop.
// Notes: One RC tick every ten clocks, so an operation lasts about 100 clocks.
`timescale 1ns/100ps
module tb;
  import fspc_pkg::*;
  logic clk = 1'b0;
  logic arst_n, gie, eeprom_write_busy, boot_size_hi, boot_size_lo;
  logic [7:0] fuse_low, fuse_high, bus_addr, bus_wdata, bus_rdata, r0_data, r1_data;
  logic io_space, bus_wr, bus_rd, spm_exec, lpm_exec, lpm_take, spm_irq, cpu_halt;
  logic rw_section_busy, flash_start, flash_wstrb;
  logic [15:0] z_ptr, flash_wdata;
  logic [7:0] lpm_data, flash_page, lock_bits, ltake, q;
  logic [13:0] boot_start;
  logic [5:0] flash_wword;
  fspc_op_t flash_op;
  logic [3:0] rcc = 4'h0;
  logic rc_tick = 1'b0;
  logic [15:0] wbuf [64];
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int starts = 0;
  int takes = 0;
  int wcnt = 0;
  always #2 clk = ~clk;
  fspc_ctrl #(.PROG_RC_TICKS(10), .PROG_MAX_CYC(200)) DUT (.clk(clk), .arst_n(arst_n),
    .io_space(io_space), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .spm_exec(spm_exec), .lpm_exec(lpm_exec),
    .z_ptr(z_ptr), .r0_data(r0_data), .r1_data(r1_data), .gie(gie),
    .eeprom_write_busy(eeprom_write_busy), .boot_size_hi(boot_size_hi),
    .boot_size_lo(boot_size_lo), .fuse_low(fuse_low), .fuse_high(fuse_high),
    .rc_tick(rc_tick), .lpm_take(lpm_take), .lpm_data(lpm_data), .spm_irq(spm_irq),
    .cpu_halt(cpu_halt), .rw_section_busy(rw_section_busy), .boot_start(boot_start),
    .flash_start(flash_start), .flash_op(flash_op), .flash_page(flash_page),
    .flash_wstrb(flash_wstrb), .flash_wword(flash_wword), .flash_wdata(flash_wdata),
    .lock_bits(lock_bits));
  fspc_cpu_model cpu (.clk(clk), .eeprom_write_busy(eeprom_write_busy),
    .bus_rdata(bus_rdata), .io_space(io_space), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .spm_exec(spm_exec), .lpm_exec(lpm_exec),
    .z_ptr(z_ptr), .r0_data(r0_data), .r1_data(r1_data));
  always @(posedge clk) begin
    rcc <= (rcc == 4'h9) ? 4'h0 : rcc + 4'h1;
    rc_tick <= (rcc == 4'h9);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
    if (flash_start === 1'b1) starts++;
    if (lpm_take === 1'b1) begin
      takes++;
      ltake = lpm_data;
    end
    if (flash_wstrb === 1'b1) begin
      wbuf[flash_wword] = flash_wdata;
      wcnt++;
    end
  end
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (flash_op !== FSPC_OP_NONE && n < 400) begin
      @(posedge clk);
      n++;
    end
    #1 chk(16'(n < 150), 16'h1);
  endtask
  task automatic t_regs;
    logic [13:0] bs [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
    cpu.acc(1'b0, 8'h37, 1'b0, 8'h00, q);
    chk(q, 8'h00);
    chk(lock_bits, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {boot_size_hi, boot_size_lo} <= i[1:0];
      #1 chk(boot_start, bs[i]);
    end
    cpu.acc(1'b0, 8'h37, 1'b1, 8'hA0, q);
    cpu.acc(1'b1, 8'h57, 1'b0, 8'h00, q);
    chk(q, 8'h80);
    chk(spm_irq, 1'b0);
    @(posedge clk);
    gie <= 1'b1;
    #1 chk(spm_irq, 1'b1);
    cpu.acc(1'b0, 8'h36, 1'b1, 8'h00, q);
    cpu.acc(1'b0, 8'h37, 1'b0, 8'h00, q);
    chk(q, 8'h80);
  endtask
  task automatic t_erase;
    int s;
    s = starts;
    cpu.cmd(5'h03, 16'h8800, 8'h00, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk(16'(starts - s), 16'h1);
    chk(flash_op, FSPC_OP_ERASE);
    chk(flash_page, 8'h10);
    chk(rw_section_busy, 1'b1);
    chk(spm_irq, 1'b0);
    cpu.acc(1'b0, 8'h37, 1'b1, 8'h91, q);
    cpu.acc(1'b0, 8'h37, 1'b0, 8'h00, q);
    chk(q, 8'hC3);
    wait_idle();
    chk(rw_section_busy, 1'b1);
    cpu.cmd(5'h11, 16'h0000, 8'h00, 8'h00);
    @(posedge clk);
    #1 chk(rw_section_busy, 1'b0);
    cpu.cmd(5'h03, 16'h0800, 8'h00, 8'h00);
    wait_idle();
    cpu.cmd(5'h01, 16'h0006, 8'hA5, 8'h3C);
    @(posedge clk);
    #1 chk(rw_section_busy, 1'b0);
  endtask
  task automatic t_write;
    wcnt = 0;
    cpu.cmd(5'h05, 16'h72BE, 8'h11, 8'h22);
    repeat (3) @(posedge clk);
    #1 chk(cpu_halt, 1'b1);
    chk(flash_op, FSPC_OP_WRITE);
    chk(flash_page, 8'hE5);
    chk(rw_section_busy, 1'b0);
    wait_idle();
    chk(cpu_halt, 1'b0);
    chk(16'(wcnt), 16'd64);
    chk(wbuf[3], 16'hA53C);
    chk(wbuf[63], 16'hFFFF);
    cpu.cmd(5'h01, 16'h000A, 8'h12, 8'h34);
    cpu.cmd(5'h11, 16'h0000, 8'h00, 8'h00);
    cpu.cmd(5'h01, 16'h000E, 8'h56, 8'h78);
    cpu.cmd(5'h05, 16'h1000, 8'h00, 8'h00);
    wait_idle();
    chk(wbuf[5], 16'hFFFF);
    chk(wbuf[7], 16'h5678);
    chk(rw_section_busy, 1'b1);
  endtask
  task automatic t_lock;
    logic [7:0] ex [3] = '{8'hF3, 8'h5A, 8'hC6};
    logic [15:0] zs [3] = '{16'h0001, 16'h0000, 16'h0002};
    cpu.cmd(5'h09, 16'h0001, 8'hFF, 8'hF3);
    wait_idle();
    chk(lock_bits, 8'hF3);
    for (int i = 0; i < 3; i++) begin
      takes = 0;
      cpu.acc(1'b0, 8'h37, 1'b1, 8'h89, q);
      cpu.ex(1'b1, zs[i], 8'h00, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk(16'(takes), 16'h1);
      chk(ltake, ex[i]);
    end
  endtask
  task automatic t_refuse;
    int s;
    logic [4:0] cs [3] = '{5'h01, 5'h03, 5'h07};
    s = starts;
    for (int i = 0; i < 3; i++) begin
      cpu.acc(1'b0, 8'h37, 1'b1, {3'b100, cs[i]}, q);
      repeat (3) @(posedge clk);
      cpu.ex(1'b0, 16'h0800, 8'h00, 8'h00);
      cpu.acc(1'b0, 8'h37, 1'b0, 8'h00, q);
      chk(q, 8'hC0);
    end
    cpu.acc(1'b0, 8'h37, 1'b1, 8'h81, q);
    repeat (2) @(posedge clk);
    cpu.ex(1'b0, 16'h0800, 8'h00, 8'h00);
    cpu.acc(1'b0, 8'h37, 1'b0, 8'h00, q);
    chk(q, 8'h80);
    takes = 0;
    @(posedge clk);
    eeprom_write_busy <= 1'b1;
    cpu.acc(1'b0, 8'h37, 1'b1, 8'h85, q);
    cpu.ex(1'b0, 16'h0800, 8'h00, 8'h00);
    cpu.acc(1'b0, 8'h37, 1'b1, 8'h89, q);
    cpu.ex(1'b1, 16'h0001, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(16'(starts - s), 16'h0);
    chk(16'(takes), 16'h0);
    @(posedge clk);
    eeprom_write_busy <= 1'b0;
  endtask
  initial begin
    arst_n = 1'b0;
    gie = 1'b0;
    eeprom_write_busy = 1'b0;
    {boot_size_hi, boot_size_lo} = 2'b11;
    fuse_low = 8'h5A;
    fuse_high = 8'hC6;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_erase();
    t_write();
    t_lock();
    t_refuse();
    complete_run();
  end
endmodule
